// File: dv/smc_mode_clk_cfg_checker.sv
`timescale 1ns/10ps
module smc_mode_clk_cfg_checker (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       powerdown_bar_pin,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       rx_lock,
   input wire logic       ref_clock_input_tick,
   input wire logic       ext_clk_detected,
   input wire logic       highspeed_tick,
   input wire logic       raw10_parallel_select,
   input wire logic       ref_int_tick,
   input wire logic       osc_range_48m,
   input wire logic       sensor_ref_output,
   input wire logic [2:0] mode_strap,
   input wire logic [2:0] active_mode,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_strap; $rose(powerdown_bar_pin) |=>
      active_mode == $past(mode_strap); endproperty
   a_strap: assert property (p_strap) else $error("strap lost");
   property p_mode; $changed(active_mode) |-> $past(reg_wr && reg_addr ==
      8'h03) || $past(powerdown_bar_pin) && !$past(powerdown_bar_pin, 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode moved");
   property p_legal; active_mode inside {3'h0, 3'h2, 3'h3, 3'h5}; endproperty
   a_legal: assert property (p_legal) else $error("bad mode");
   property p_load; $changed(raw10_parallel_select) |-> $past(reg_wr &&
      reg_addr == 8'h04) || $past(rx_lock) && !$past(rx_lock, 2); endproperty
   a_load: assert property (p_load) else $error("sub-mode moved");
   property p_rdiv; ref_int_tick |-> $past(ref_clock_input_tick);
   endproperty
   a_rdiv: assert property (p_rdiv) else $error("stray ref tick");
   property p_osc; osc_range_48m |-> active_mode == 3'h3 ||
      !ext_clk_detected; endproperty
   a_osc: assert property (p_osc) else $error("osc range");
   property p_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("rdata moved");
   property p_unmap; reg_rd && (reg_addr < 8'h03 || reg_addr > 8'h07) |=>
      reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_sro; $changed(sensor_ref_output) |-> $past(highspeed_tick);
   endproperty
   a_sro: assert property (p_sro) else $error("stray out edge");
endmodule
bind smc_mode_clk_cfg smc_mode_clk_cfg_checker chk_u (.clk, .reset_n,
   .powerdown_bar_pin, .reg_wr, .reg_rd, .rx_lock, .ref_clock_input_tick,
   .ext_clk_detected, .highspeed_tick, .raw10_parallel_select,
   .ref_int_tick, .osc_range_48m, .sensor_ref_output,
   .mode_strap, .active_mode, .reg_addr, .reg_rdata);

// File: dv/smc_sensor_model.sv
`timescale 1ns/10ps
module smc_sensor_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic sensor_ref_output,
   output int        edges
);
   logic last_r;
   // Sensor only sees level changes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         last_r <= 1'h0;
         edges <= 0;
      end else begin
         last_r <= sensor_ref_output;
         edges <= edges + int'(last_r != sensor_ref_output);
      end
   end
endmodule

// File: dv/tb_serializer_mode_and_sensor_ref_output_cfg.sv
`timescale 1ns/10ps
module tb_serializer_mode_and_sensor_ref_output_cfg;
   logic       clk = 1'h0, reset_n = 1'h0, pin = 1'h0, wr = 1'h0, rd = 1'h0;
   logic       lock = 1'h0, b10 = 1'h0, b12 = 1'h0, ext = 1'h1, rt = 1'h0;
   logic       ht = 1'h0, itk, osc, sro, s10, s12;
   logic [2:0] strap = 3'h0, am;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
   logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h03, 8'h41, 8'h28};
   int         bad_count = 0, n_compared = 0, ticks = 0, tg, prev;
   always #2 clk = ~clk;
   always @(posedge clk) if (itk) ticks <= ticks + 1;
   smc_mode_clk_cfg dut_u (.clk, .reset_n, .powerdown_bar_pin(pin),
      .mode_strap(strap), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
      .reg_wdata(wd), .reg_rdata(rdat), .rx_lock(lock), .bcc_raw10(b10),
      .bcc_raw12(b12), .ext_clk_detected(ext), .ref_clock_input_tick(rt),
      .highspeed_tick(ht), .active_mode(am), .raw10_parallel_select(s10),
      .raw12_parallel_select(s12), .ref_int_tick(itk), .osc_range_48m(osc),
      .sensor_ref_output(sro));
   smc_sensor_model sen_u (.clk, .reset_n, .sensor_ref_output(sro),
      .edges(tg));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(posedge clk);
      chk(rdat, e);
   endtask
   // Whole divider periods only, so phase cannot skew counts
   task automatic run(input int n);
      repeat (n) begin
         rt <= 1'h1;
         ht <= 1'h1;
         @(posedge clk);
         rt <= 1'h0;
         ht <= 1'h0;
         @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) rchk(8'h03 + 8'(i), rst[i]);
      strap <= 3'h3;
      pin <= 1'h1;
      repeat (2) @(posedge clk);
      chk({5'h00, am}, 8'h03);
      rchk(8'h03, 8'h0B);
      wreg(8'h03, 8'h05);
      rchk(8'h03, 8'h0B);
      wreg(8'h03, 8'h10);
      prev = 3;
      for (int c = 0; c < 8; c++) begin
         wreg(8'h03, 8'h10 | 8'(c));
         if (c inside {0, 2, 3, 5}) prev = c;
         rchk(8'h03, 8'h18 | 8'(prev));
      end
      $display("mode test done");
      wreg(8'h05, 8'h0B);
      chk({7'h00, osc}, 8'h00);
      ext <= 1'h0;
      @(posedge clk);
      chk({7'h00, osc}, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wreg(8'h05, 8'(c << 4) | 8'h03);
         prev = ticks;
         run(32);
         chk(8'(ticks - prev), 8'(32 >> c));
      end
      wreg(8'h05, 8'h43);
      rchk(8'h05, 8'h33);
      $display("divider test done");
      // Ratio one quarter keeps the output far below the limit
      wreg(8'h07, 8'h04);
      wreg(8'h06, 8'h21);
      // Drain accumulator left high by the divider runs
      run(64);
      prev = tg;
      run(64);
      chk(8'(tg - prev), 8'h10);
      wreg(8'h06, 8'hA1);
      rchk(8'h06, 8'h21);
      wreg(8'h06, 8'h20);
      prev = tg;
      run(64);
      chk(8'(tg - prev), 8'h00);
      $display("clock out test done");
      b10 <= 1'h1;
      lock <= 1'h1;
      repeat (2) @(posedge clk);
      chk({6'h00, s10, s12}, 8'h02);
      wreg(8'h04, 8'h03);
      lock <= 1'h0;
      b12 <= 1'h1;
      @(posedge clk);
      lock <= 1'h1;
      repeat (2) @(posedge clk);
      rchk(8'h04, 8'h03);
      rchk(8'h20, 8'h00);
      $display("lock test done");
      print_verdict;
   end
endmodule

// File: rtl/smc_mode_clk_cfg.sv
`timescale 1ns/10ps
// Operation
// - Mode field shows active mode; writable only while override enable set
// - Strapped mode captured on power-down pin low-to-high edge
// - Mode-done status bit, reset zero, rises once mode captured
// - Mode codes 000 sync, 010 ext clock, 011 always-on, 101 parallel
// - On receive lock, control channel loads RAW10 and RAW12 sub-mode bits
// - Lock enable bit set blocks control-channel auto-load of sub-mode bits
// - Reference input divided by 1, 2, 4 or 8; codes 100-111 reserved
// - Oscillator range select picks 24.2 or 48.4 MHz when it applies
// - Ratio source is high-speed clock divided 1..16; prescale resets 2
// - Sensor reference is prescaled clock times M over N; M resets 1
// - Multiplier zero holds sensor reference output static
module smc_mode_clk_cfg (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       powerdown_bar_pin,
   input  wire logic [2:0] mode_strap,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       rx_lock,
   input  wire logic       bcc_raw10,
   input  wire logic       bcc_raw12,
   input  wire logic       ext_clk_detected,
   input  wire logic       ref_clock_input_tick,
   input  wire logic       highspeed_tick,
   output logic      [2:0] active_mode,
   output logic            raw10_parallel_select,
   output logic            raw12_parallel_select,
   output logic            ref_int_tick,
   output logic            osc_range_48m,
   output logic            sensor_ref_output
);
   logic [7:0] mode_reg_r,   mode_reg_nxt;
   logic [7:0] sub_reg_r,    sub_reg_nxt;
   logic [7:0] ref_reg_r,    ref_reg_nxt;
   logic [7:0] clk0_reg_r,   clk0_reg_nxt;
   logic [7:0] divisor_r,    divisor_nxt;
   logic [7:0] rdata_r,      rdata_nxt;
   logic       pdb_q_r,      lock_q_r;
   logic [2:0] refcnt_r,     refcnt_nxt;
   logic       ref_tick_r,   ref_tick_nxt;
   logic [3:0] precnt_r,     precnt_nxt;
   logic [8:0] acc_r,        acc_nxt;
   logic       out_r,        out_nxt;
   logic       pre_tick;
   logic [2:0] refmask;
   logic [3:0] premask;
   logic [8:0] acc_sum;
   logic       wr_mode, wr_sub, wr_ref, wr_clk0;

   assign wr_mode = reg_wr && (reg_addr == smc_pkg::ADDR_MODE);
   assign wr_sub  = reg_wr && (reg_addr == smc_pkg::ADDR_SUBMODE);
   assign wr_ref  = reg_wr && (reg_addr == smc_pkg::ADDR_REFCLK);
   assign wr_clk0 = reg_wr && (reg_addr == smc_pkg::ADDR_CLKOUT0);

   // Register file next values
   always_comb begin
      mode_reg_nxt = mode_reg_r;
      sub_reg_nxt  = sub_reg_r;
      ref_reg_nxt  = ref_reg_r;
      clk0_reg_nxt = clk0_reg_r;
      divisor_nxt  = divisor_r;
      if (wr_mode) begin
         mode_reg_nxt[7:3] = {reg_wdata[7], 1'b0, reg_wdata[5:4],
                              mode_reg_r[smc_pkg::MODE_DONE_BIT]};
         if (mode_reg_r[smc_pkg::MODE_OVERRIDE_ENABLE_BIT] &&
             (reg_wdata[2:0] == smc_pkg::SMC_MODE_CSI_SYNC  ||
              reg_wdata[2:0] == smc_pkg::SMC_MODE_NSYNC_EXT ||
              reg_wdata[2:0] == smc_pkg::SMC_MODE_NSYNC_AON ||
              reg_wdata[2:0] == smc_pkg::SMC_MODE_PARALLEL))
            mode_reg_nxt[2:0] = reg_wdata[2:0];
      end
      if (powerdown_bar_pin && !pdb_q_r) begin
         mode_reg_nxt[2:0] = mode_strap;
         mode_reg_nxt[smc_pkg::MODE_DONE_BIT] = 1'b1;
      end
      if (rx_lock && !lock_q_r && !sub_reg_r[smc_pkg::SUB_LOCK_BIT]) begin
         sub_reg_nxt[smc_pkg::SUB_RAW10_BIT] = bcc_raw10;
         sub_reg_nxt[smc_pkg::SUB_RAW12_BIT] = bcc_raw12;
      end
      // Software write wins over a same-cycle auto-load
      if (wr_sub)
         sub_reg_nxt = reg_wdata;
      if (wr_ref) begin
         ref_reg_nxt[7] = reg_wdata[7];
         ref_reg_nxt[3:0] = reg_wdata[3:0];
         if (reg_wdata[6:4] <= smc_pkg::REFDIV_MAX)
            ref_reg_nxt[6:4] = reg_wdata[6:4];
      end
      if (wr_clk0) begin
         clk0_reg_nxt[4:0] = reg_wdata[4:0];
         if (reg_wdata[7:5] <= smc_pkg::PRESCALE_MAX)
            clk0_reg_nxt[7:5] = reg_wdata[7:5];
      end
      if (reg_wr && (reg_addr == smc_pkg::ADDR_CLKOUT1))
         divisor_nxt = reg_wdata;
   end

   // Read data, registered; unmapped reads zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         unique case (reg_addr)
            smc_pkg::ADDR_MODE:    rdata_nxt = mode_reg_r;
            smc_pkg::ADDR_SUBMODE: rdata_nxt = sub_reg_r;
            smc_pkg::ADDR_REFCLK:  rdata_nxt = ref_reg_r;
            smc_pkg::ADDR_CLKOUT0: rdata_nxt = clk0_reg_r;
            smc_pkg::ADDR_CLKOUT1: rdata_nxt = divisor_r;
            default:               rdata_nxt = 8'h00;
         endcase
      end
   end

   always_comb begin
      refmask      = 3'((4'h1 << ref_reg_r[6:4]) - 4'h1);
      refcnt_nxt   = refcnt_r;
      ref_tick_nxt = 1'b0;
      if (ref_clock_input_tick) begin
         if ((refcnt_r & refmask) == refmask) begin
            refcnt_nxt   = 3'h0;
            ref_tick_nxt = 1'b1;
         end else begin
            refcnt_nxt = refcnt_r + 3'h1;
         end
      end
   end

   always_comb begin
      premask    = 4'((5'h01 << clk0_reg_r[7:5]) - 5'h01);
      pre_tick   = highspeed_tick && ((precnt_r & premask) == premask);
      precnt_nxt = precnt_r;
      if (highspeed_tick)
         precnt_nxt = pre_tick ? 4'h0 : precnt_r + 4'h1;
   end

   // M/N accumulator, two edges per cycle
   always_comb begin
      acc_sum = acc_r + {3'h0, clk0_reg_r[4:0], 1'b0};
      acc_nxt = acc_r;
      out_nxt = out_r;
      if (pre_tick && clk0_reg_r[4:0] != 5'h00) begin
         if (acc_sum >= {1'b0, divisor_r}) begin
            acc_nxt = acc_sum - {1'b0, divisor_r};
            out_nxt = !out_r;
         end else begin
            acc_nxt = acc_sum;
         end
      end
   end

   // Register file and edge detectors; pin sample resets low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg_r <= {5'h00, smc_pkg::MODE_RST};
         sub_reg_r  <= 8'h00;
         ref_reg_r  <= {1'b0, smc_pkg::REFDIV_RST, 1'b0,
                        smc_pkg::REF_RSVD_RST};
         clk0_reg_r <= {smc_pkg::PRESCALE_RST, smc_pkg::MULT_RST};
         divisor_r  <= smc_pkg::DIVISOR_RST;
         pdb_q_r    <= 1'b0;
         lock_q_r   <= 1'b0;
      end else begin
         mode_reg_r <= mode_reg_nxt;
         sub_reg_r  <= sub_reg_nxt;
         ref_reg_r  <= ref_reg_nxt;
         clk0_reg_r <= clk0_reg_nxt;
         divisor_r  <= divisor_nxt;
         pdb_q_r    <= powerdown_bar_pin;
         lock_q_r   <= rx_lock;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         refcnt_r   <= 3'h0;
         ref_tick_r <= 1'b0;
      end else begin
         refcnt_r   <= refcnt_nxt;
         ref_tick_r <= ref_tick_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         precnt_r <= 4'h0;
      end else begin
         precnt_r <= precnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_r <= 9'h000;
         out_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         out_r <= out_nxt;
      end
   end

   assign active_mode           = mode_reg_r[2:0];
   assign raw10_parallel_select = sub_reg_r[smc_pkg::SUB_RAW10_BIT];
   assign raw12_parallel_select = sub_reg_r[smc_pkg::SUB_RAW12_BIT];
   assign reg_rdata             = rdata_r;
   assign ref_int_tick          = ref_tick_r;
   assign sensor_ref_output     = out_r;
   // range applies for always-on mode or no clock
   assign osc_range_48m = ref_reg_r[smc_pkg::OSC_SEL_BIT] &&
      (mode_reg_r[2:0] == smc_pkg::SMC_MODE_NSYNC_AON || !ext_clk_detected);
endmodule

// File: rtl/smc_pkg.sv
package smc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_MODE    = 8'h03;
   localparam logic [7:0] ADDR_SUBMODE = 8'h04;
   localparam logic [7:0] ADDR_REFCLK  = 8'h05;
   localparam logic [7:0] ADDR_CLKOUT0 = 8'h06;
   localparam logic [7:0] ADDR_CLKOUT1 = 8'h07;

   // Field positions
   localparam int MODE_OVERRIDE_ENABLE_BIT    = 4;
   localparam int MODE_DONE_BIT  = 3;
   localparam int SUB_RAW10_BIT  = 2;
   localparam int SUB_RAW12_BIT  = 1;
   localparam int SUB_LOCK_BIT   = 0;
   localparam int REF_DIV_LSB    = 4;
   localparam int OSC_SEL_BIT    = 3;
   localparam int PRESCALE_LSB   = 5;

   // Values after reset
   localparam logic [2:0] MODE_RST      = 3'h0;
   localparam logic [2:0] REFDIV_RST    = 3'h0;
   localparam logic [2:0] REF_RSVD_RST  = 3'h3;
   localparam logic [2:0] PRESCALE_RST  = 3'h2;
   localparam logic [4:0] MULT_RST      = 5'h01;
   localparam logic [7:0] DIVISOR_RST   = 8'h28;

   // Mode codes
   typedef enum logic [2:0] {
      SMC_MODE_CSI_SYNC   = 3'b000,
      SMC_MODE_RSVD       = 3'b001,
      SMC_MODE_NSYNC_EXT  = 3'b010,
      SMC_MODE_NSYNC_AON  = 3'b011,
      SMC_MODE_PARALLEL   = 3'b101
   } smc_mode_t;

   // Largest legal divider codes
   localparam logic [2:0] REFDIV_MAX    = 3'h3;
   localparam logic [2:0] PRESCALE_MAX  = 3'h4;
endpackage
